//--- rtl/sleep_wake_pkg.sv
// Shared constants and types for the sleep and wake controller
package sleep_wake_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_DIV_CYCLES = CLK_HZ / 1000;
  localparam int unsigned SLEEP_DELAY_MS = 2000;
  localparam int unsigned AUTO_SLEEP_MS = 2000;
  localparam int unsigned WAKE_LIMIT_MS = 50;
  localparam int unsigned WAKE_DELAY_MS = 1;
  localparam int unsigned RING_CALL_PERIOD_MS = 5000;
  localparam int unsigned RING_CALL_WIDTH_MS = 30;
  localparam int unsigned RING_SMS_WIDTH_MS = 25;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned MS_CNT_W = 13;

  typedef enum logic [1:0] {
    PWR_AWAKE = 2'b00,
    PWR_WAKING = 2'b01,
    PWR_ASLEEP = 2'b10
  } power_state_type;

  typedef struct packed {
    logic incoming_call;
    logic call_connected;
    logic sms_arrived;
    logic data_call;
    logic server_data;
  } net_event_type;

  typedef struct packed {
    logic serial_en;
    logic asleep;
    logic report_event;
    logic indicator;
    logic ring_n;
  } power_out_type;

endpackage

//--- rtl/sleep_wake_ctrl.sv
// Sleep entry, wake-up, ring pulse and indicator control of the data module
//
// Functional notes
// - Sleep only after power-save enabled with DTR high
// - Indicator stops blinking once power saving enabled
// - DTR low with power saving: sleep after 2s
// - Serial port disabled while asleep
// - Sleep postponed until serial transfer finishes
// - DTR rising wakes device within 50ms
// - Network event wakes device and reports it
// - Host raises then lowers DTR; device re-sleeps
// - Unhandled event wake re-sleeps after 2s
// - Serial receive data wakes sleeping device
// - Call ring: 30ms low pulses every 5s
// - SMS with reminders: one 25ms low pulse
// - Data call leaves ring output high
// - Call ring period 5s, width 30ms
// - Connected call stops ring, holds high
// - Awake and operating: indicator blinks once per second
`timescale 1ns/1ps
module sleep_wake_ctrl
  import sleep_wake_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_DIV_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Host control
  input wire logic dtr,
  input wire logic power_save_enable_command,
  input wire logic sms_reminder_en,
  // Serial activity
  input wire logic uart_busy,
  input wire logic rx_activity,
  // Network events
  input wire net_event_type net_event,
  // Status outputs
  output power_out_type pwr_out
);

  function automatic logic [MS_CNT_W-1:0] ms_val(input int unsigned ms);
    ms_val = MS_CNT_W'(ms);
  endfunction

  // Millisecond tick divider
  logic [31:0] div_cnt;
  wire ms_tick = (div_cnt == MS_CYCLES - 1);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
    end else if (ms_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end

  // Power-save setting is taken only while DTR is high
  logic pwr_save;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_save <= 1'b0;
    end else if (power_save_enable_command && dtr) begin
      pwr_save <= 1'b1;
    end
  end

  logic dtr_q;
  logic event_wake;
  power_state_type state;
  power_state_type next_state;
  logic [MS_CNT_W-1:0] slp_ms;
  logic [MS_CNT_W-1:0] wake_ms;

  wire dtr_rise = dtr && !dtr_q;
  wire net_wake = net_event.incoming_call || net_event.sms_arrived || net_event.server_data;
  // Any wake condition resets the sleep timer, so the timeout runs only when idle
  wire wake_pending = dtr || uart_busy || rx_activity || net_wake;
  wire sleep_limit = event_wake ? (slp_ms >= ms_val(AUTO_SLEEP_MS))
                                : (slp_ms >= ms_val(SLEEP_DELAY_MS));
  wire go_sleep = (state == PWR_AWAKE) && pwr_save && !wake_pending
                  && sleep_limit && ms_tick;
  wire asleep_wake = (state == PWR_ASLEEP) && (dtr_rise || dtr || rx_activity || net_wake);

  always_comb begin
    next_state = state;
    unique case (state)
      PWR_AWAKE: begin
        if (go_sleep) begin
          next_state = PWR_ASLEEP;
        end
      end
      PWR_ASLEEP: begin
        if (asleep_wake) begin
          next_state = PWR_WAKING;
        end
      end
      PWR_WAKING: begin
        if (ms_tick && wake_ms >= ms_val(WAKE_DELAY_MS)) begin
          next_state = PWR_AWAKE;
        end
      end
      default: next_state = PWR_AWAKE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= PWR_AWAKE;
      dtr_q <= 1'b0;
      event_wake <= 1'b0;
      slp_ms <= '0;
      wake_ms <= '0;
    end else begin
      state <= next_state;
      dtr_q <= dtr;
      if (state == PWR_ASLEEP && net_wake) begin
        event_wake <= 1'b1;
      end else if (dtr || rx_activity || next_state == PWR_ASLEEP) begin
        event_wake <= 1'b0;
      end
      if (state != PWR_AWAKE || wake_pending) begin
        slp_ms <= '0;
      end else if (ms_tick && !sleep_limit) begin
        slp_ms <= slp_ms + 1'b1;
      end
      if (state != PWR_WAKING) begin
        wake_ms <= '0;
      end else if (ms_tick) begin
        wake_ms <= wake_ms + 1'b1;
      end
    end
  end

  // Ring pattern: a call owns the pin; an SMS gets one pulse when no call rings
  logic call_active;
  logic [MS_CNT_W-1:0] ring_ms;
  logic [MS_CNT_W-1:0] sms_ms;
  logic sms_active;
  wire call_start = net_event.incoming_call && !net_event.data_call && !call_active;
  wire call_low = call_active && (ring_ms < ms_val(RING_CALL_WIDTH_MS));
  wire sms_low = sms_active && !call_active;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      call_active <= 1'b0;
      ring_ms <= '0;
      sms_active <= 1'b0;
      sms_ms <= '0;
    end else begin
      if (net_event.call_connected || !net_event.incoming_call || net_event.data_call) begin
        call_active <= 1'b0;
        ring_ms <= '0;
      end else if (call_start) begin
        call_active <= 1'b1;
        ring_ms <= '0;
      end else if (ms_tick) begin
        ring_ms <= (ring_ms == ms_val(RING_CALL_PERIOD_MS - 1)) ? '0 : ring_ms + 1'b1;
      end
      if (net_event.sms_arrived && sms_reminder_en && !sms_active) begin
        sms_active <= 1'b1;
        sms_ms <= '0;
      end else if (sms_active && ms_tick) begin
        if (sms_ms == ms_val(RING_SMS_WIDTH_MS - 1)) begin
          sms_active <= 1'b0;
        end
        sms_ms <= sms_ms + 1'b1;
      end
    end
  end

  // Indicator: 1 Hz blink while awake and power saving off
  logic [MS_CNT_W-1:0] blink_ms;
  logic blink;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      blink_ms <= '0;
      blink <= 1'b0;
    end else if (ms_tick) begin
      if (blink_ms == ms_val(BLINK_HALF_MS - 1)) begin
        blink_ms <= '0;
        blink <= !blink;
      end else begin
        blink_ms <= blink_ms + 1'b1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_out <= '{serial_en: 1'b1, asleep: 1'b0, report_event: 1'b0,
                   indicator: 1'b0, ring_n: 1'b1};
    end else begin
      pwr_out.serial_en <= (next_state != PWR_ASLEEP);
      pwr_out.asleep <= (next_state == PWR_ASLEEP);
      pwr_out.report_event <= (state == PWR_ASLEEP) && net_wake;
      pwr_out.indicator <= pwr_save ? 1'b0 : blink;
      pwr_out.ring_n <= !(call_low || sms_low);
    end
  end

  // Checks
  AST_NO_SLEEP_WITHOUT_SAVE: assert property (@(posedge core_clk) disable iff (!arst_n)
    !pwr_save |-> state != PWR_ASLEEP) else $error("asleep without power save");
  AST_SLEEP_NEEDS_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == PWR_AWAKE && next_state == PWR_ASLEEP) |-> !uart_busy && !dtr)
    else $error("sleep entered while busy");
  AST_SERIAL_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
    state == PWR_ASLEEP |=> !pwr_out.serial_en || $past(asleep_wake))
    else $error("serial enabled while asleep");
  AST_WAKE_DTR: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == PWR_ASLEEP && dtr) |=> state == PWR_WAKING) else $error("dtr did not wake");
  AST_WAKE_RX: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == PWR_ASLEEP && rx_activity) |=> state == PWR_WAKING) else $error("rx no wake");
  AST_EVENT_REPORT: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == PWR_ASLEEP && net_wake) |=> pwr_out.report_event) else $error("no report");
  AST_INDICATOR_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
    pwr_save |=> !pwr_out.indicator) else $error("indicator blinking in power save");
  AST_RING_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!call_active && !sms_active) |=> pwr_out.ring_n) else $error("ring low when idle");
  // An SMS arriving in the same cycle may legally pulse the pin two edges later
  AST_RING_CONNECTED: assert property (@(posedge core_clk) disable iff (!arst_n)
    (net_event.call_connected && !sms_active && !net_event.sms_arrived) |=> ##1 pwr_out.ring_n)
    else $error("ring active after connect");
  AST_DATA_CALL: assert property (@(posedge core_clk) disable iff (!arst_n)
    (net_event.data_call && !sms_active && !net_event.sms_arrived) |=> ##1 pwr_out.ring_n)
    else $error("ring on data call");

  // Wake path
  AST_WAKE_EVENT: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == PWR_ASLEEP && net_wake) |=> state == PWR_WAKING)
    else $error("event did not wake");
  AST_WAKE_BOUND: assert property (@(posedge core_clk) disable iff (!arst_n)
    state == PWR_WAKING |-> wake_ms < ms_val(WAKE_LIMIT_MS))
    else $error("wake took too long");
  AST_NO_REPORT_AWAKE: assert property (@(posedge core_clk) disable iff (!arst_n)
    state != PWR_ASLEEP |=> !pwr_out.report_event)
    else $error("event report while awake");

  // Sleep entry
  AST_RX_BLOCKS_SLEEP: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == PWR_AWAKE && (rx_activity || uart_busy)) |-> next_state == PWR_AWAKE)
    else $error("sleep entered during serial traffic");
  AST_ASLEEP_FLAG: assert property (@(posedge core_clk) disable iff (!arst_n)
    next_state == PWR_ASLEEP |=> pwr_out.asleep && !pwr_out.serial_en)
    else $error("asleep flag not shown");
  AST_STATE_LEGAL: assert property (@(posedge core_clk) disable iff (!arst_n)
    state inside {PWR_AWAKE, PWR_WAKING, PWR_ASLEEP})
    else $error("illegal power state");
  AST_SAVE_STICKY: assert property (@(posedge core_clk) disable iff (!arst_n)
    pwr_save |=> pwr_save)
    else $error("power save dropped");
  // The event flag must be clear on entry so the auto re-sleep timer is chosen fresh
  AST_EVENT_FLAG_CLEAR: assert property (@(posedge core_clk) disable iff (!arst_n)
    state == PWR_ASLEEP |-> !event_wake)
    else $error("event flag stale while asleep");

  // Ring and indicator counters stay inside their patterns
  AST_CALL_STARTS: assert property (@(posedge core_clk) disable iff (!arst_n)
    (call_start && !net_event.call_connected) |=> call_active)
    else $error("call ring did not start");
  AST_CALL_LOW: assert property (@(posedge core_clk) disable iff (!arst_n)
    (call_active && ring_ms == '0) |=> !pwr_out.ring_n)
    else $error("call pulse missing");
  AST_RING_PERIOD: assert property (@(posedge core_clk) disable iff (!arst_n)
    ring_ms < ms_val(RING_CALL_PERIOD_MS))
    else $error("ring period overrun");
  AST_SMS_WIDTH: assert property (@(posedge core_clk) disable iff (!arst_n)
    sms_active |-> sms_ms < ms_val(RING_SMS_WIDTH_MS))
    else $error("sms pulse too long");
  AST_SMS_NEEDS_ENABLE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!sms_active && !sms_reminder_en) |=> !sms_active)
    else $error("sms pulse without reminders");
  AST_BLINK_BOUND: assert property (@(posedge core_clk) disable iff (!arst_n)
    blink_ms < ms_val(BLINK_HALF_MS))
    else $error("blink half period overrun");
  // A divider past its end would stall every millisecond timer at once
  AST_TICK_BOUND: assert property (@(posedge core_clk) disable iff (!arst_n)
    div_cnt < MS_CYCLES)
    else $error("tick divider overrun");

  COV_SLEEP: cover property (@(posedge core_clk) disable iff (!arst_n)
    state == PWR_AWAKE ##1 state == PWR_ASLEEP);
  COV_DTR_WAKE: cover property (@(posedge core_clk) disable iff (!arst_n)
    state == PWR_ASLEEP && dtr ##1 state == PWR_WAKING);
  COV_EVENT_WAKE: cover property (@(posedge core_clk) disable iff (!arst_n)
    state == PWR_ASLEEP && net_wake);
  COV_RING: cover property (@(posedge core_clk) disable iff (!arst_n) $fell(pwr_out.ring_n));
  COV_SMS_PULSE: cover property (@(posedge core_clk) disable iff (!arst_n)
    sms_active && !call_active);

endmodule

//--- tb/host_model.sv
// Host microcontroller model: terminal-ready, command strobe, serial traffic
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic core_clk,
  // Host lines
  output logic dtr,
  output logic power_save_enable_command,
  output logic rx_activity
);
  initial begin
    dtr = 1'b1;
    power_save_enable_command = 1'b0;
    rx_activity = 1'b0;
  end
  task automatic set_dtr(input logic v);
    @(posedge core_clk);
    dtr <= v;
  endtask
  // Command is only honoured while terminal-ready is high
  task automatic enable_power_save();
    @(posedge core_clk);
    dtr <= 1'b1;
    power_save_enable_command <= 1'b1;
    @(posedge core_clk);
    power_save_enable_command <= 1'b0;
  endtask
  task automatic send_chars(input int n);
    int k;
    k = (n > 30) ? 30 : n;
    repeat (k) begin
      @(posedge core_clk);
      rx_activity <= 1'b1;
      @(posedge core_clk);
      rx_activity <= 1'b0;
    end
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the sleep and wake controller
`timescale 1ns/1ps
module tb_top;
  import sleep_wake_pkg::*;
  localparam int M = 4;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sms_reminder_en = 1'b0;
  logic uart_busy = 1'b0;
  net_event_type net_event = '0;
  logic dtr, power_save_enable_command, rx_activity;
  power_out_type pwr_out;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n, s1, s2;
  host_model HOST (.core_clk(core_clk), .dtr(dtr),
    .power_save_enable_command(power_save_enable_command), .rx_activity(rx_activity));
  sleep_wake_ctrl #(.MS_CYCLES(M)) DUT (.core_clk(core_clk), .arst_n(arst_n), .dtr(dtr),
    .power_save_enable_command(power_save_enable_command), .sms_reminder_en(sms_reminder_en),
    .uart_busy(uart_busy), .rx_activity(rx_activity), .net_event(net_event), .pwr_out(pwr_out));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Always moves to a settled sample point before looking
  task automatic wait_bit(input int idx, input logic v, input int lim, output int k);
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (pwr_out[idx] !== v && k < lim);
    check(pwr_out[idx], v);
  endtask
  task automatic ring_low(input int w, output int st);
    int k;
    wait_bit(0, 1'b0, (RING_CALL_PERIOD_MS + 4) * M, k);
    st = cyc;
    wait_bit(0, 1'b1, (w + 4) * M, k);
    check(k >= (w - 1) * M && k <= (w + 1) * M, 1);
  endtask
  task automatic hold_high(input int lim);
    int bad;
    bad = 0;
    repeat (lim) begin
      @(negedge core_clk);
      if (pwr_out.ring_n !== 1'b1) bad++;
    end
    check(bad, 0);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #450us;
    n_errors++;
    test_done();
  end
  initial begin
    void'($urandom(79));
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    @(negedge core_clk);
    check(pwr_out, 5'h11);
    HOST.set_dtr(1'b0);
    wait_bit(1, 1'b1, (BLINK_HALF_MS + 2) * M, n);
    repeat ((SLEEP_DELAY_MS + 10) * M) @(negedge core_clk);
    check(pwr_out.asleep, 1'b0);
    HOST.enable_power_save();
    repeat (2) begin
      repeat ((BLINK_HALF_MS + 3) * M) @(negedge core_clk);
      check(pwr_out.indicator, 1'b0);
    end
    @(posedge core_clk);
    uart_busy <= 1'b1;
    HOST.set_dtr(1'b0);
    repeat ((SLEEP_DELAY_MS + 5 + $urandom_range(0, 20)) * M) @(negedge core_clk);
    check(pwr_out.asleep, 1'b0);
    @(posedge core_clk);
    uart_busy <= 1'b0;
    wait_bit(3, 1'b1, (SLEEP_DELAY_MS + 4) * M, n);
    check(n >= (SLEEP_DELAY_MS - 2) * M, 1);
    check(pwr_out.serial_en, 1'b0);
    HOST.set_dtr(1'b1);
    wait_bit(3, 1'b0, WAKE_LIMIT_MS * M, n);
    check(pwr_out.serial_en, 1'b1);
    HOST.set_dtr(1'b0);
    wait_bit(3, 1'b1, (SLEEP_DELAY_MS + 4) * M, n);
    @(posedge core_clk);
    sms_reminder_en <= 1'b1;
    net_event.sms_arrived <= 1'b1;
    @(posedge core_clk);
    net_event.sms_arrived <= 1'b0;
    wait_bit(2, 1'b1, 4, n);
    ring_low(RING_SMS_WIDTH_MS, s1);
    check(pwr_out.asleep, 1'b0);
    wait_bit(3, 1'b1, (AUTO_SLEEP_MS + 40) * M, n);
    HOST.send_chars($urandom_range(1, 30));
    wait_bit(3, 1'b0, WAKE_LIMIT_MS * M, n);
    HOST.set_dtr(1'b1);
    net_event.incoming_call <= 1'b1;
    ring_low(RING_CALL_WIDTH_MS, s1);
    ring_low(RING_CALL_WIDTH_MS, s2);
    check(s2 - s1 >= (RING_CALL_PERIOD_MS - 1) * M && s2 - s1 <= (RING_CALL_PERIOD_MS + 1) * M, 1);
    // Drop the call, then offer a new one already connected: no pulse may start
    @(posedge core_clk);
    net_event <= '0;
    @(posedge core_clk);
    net_event <= 5'h18;
    hold_high((RING_CALL_WIDTH_MS + 10) * M);
    @(posedge core_clk);
    net_event <= 5'h12;
    hold_high((RING_CALL_WIDTH_MS + 10) * M);
    test_done();
  end
endmodule
